// ---- tb/eir_pin_model.sv ----
// Pin source model: each fired pin is held high for two clock cycles
`timescale 1ns/1ps
module eir_pin_model
  import eir_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic [SRC_COUNT-1:0] i_fire,
  output logic      [SRC_COUNT-1:0] o_pins
);
  logic [SRC_COUNT-1:0] hold;
  initial begin
    o_pins = '0;
    hold = '0;
  end
  always @(posedge i_clk) begin
    o_pins <= i_fire | hold;
    hold <= i_fire;
  end
endmodule

// ---- tb/tb_external_interrupt_router.sv ----
// Testbench for the external interrupt router
`timescale 1ns/1ps
module tb_external_interrupt_router
  import eir_pkg::*;
;
  logic                 clk = 0;
  logic                 nrst = 0;
  logic [SRC_COUNT-1:0] en = '1;
  logic [SRC_COUNT-1:0] mask = '0;
  logic [SRC_COUNT-1:0] clr = '0;
  logic [SRC_COUNT-1:0] fire = '0;
  logic [SRC_COUNT-1:0] pins;
  logic                 pd = 0;
  logic                 crit = 0;
  logic [SRC_COUNT-1:0] pend;
  logic                 cint;
  logic                 nint;
  logic [SRC_IDX_W-1:0] act;
  int                   num_errors = 0;
  int                   n_compared = 0;
  always #5 clk = ~clk;
  eir_pin_model pm (.i_clk(clk), .i_fire(fire), .o_pins(pins));
  eir_router uut (.I_CLOCK(clk), .I_NRST(nrst), .I_EXT_REQUEST(pins[3:0]),
    .I_STD_PIN_IRQ(pins[11:4]), .I_WAKE_PIN_IRQ(pins[19:12]), .I_ENABLE(en),
    .I_MASK(mask), .I_CLEAR(clr), .I_POWER_DOWN(pd), .I_REQ0_CRITICAL(crit),
    .O_PENDING(pend), .O_CORE_INT(nint), .O_CORE_CINT(cint), .O_ACTIVE_SRC(act));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic fire_src(input logic [SRC_COUNT-1:0] v);
    @(posedge clk) fire <= v;
    @(posedge clk) fire <= '0;
  endtask
  task automatic clear_src(input int i);
    @(posedge clk) clr <= 20'h1 << i;
    @(posedge clk) clr <= '0;
    repeat (16) @(posedge clk);
  endtask
  task automatic wait_src(input int i);
    int k;
    k = 0;
    #1;
    while (nint !== 1'b1 && k < 30) begin
      @(posedge clk);
      #1;
      k++;
    end
    check(act, i);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_latency(input int i, input int lat, input logic c);
    fire_src(20'h1 << i);
    repeat (lat - 1) @(posedge clk);
    #1 check({nint, cint}, 0);
    @(posedge clk);
    #1 check({nint, cint}, c ? 1 : 2);
    check(act, i);
    check(pend[i], 1);
    clear_src(i);
  endtask
  task automatic t_sources;
    crit <= 1;
    t_latency(0, 10, 1);
    crit <= 0;
    for (int i = 0; i < SRC_COUNT; i++) t_latency(i, i < 4 ? 10 : 12, 0);
  endtask
  task automatic t_mask_repeat;
    mask <= 20'h2020;
    fire_src(20'h20);
    repeat (14) @(posedge clk);
    #1 check({nint, pend[5]}, 1);
    @(posedge clk) mask[5] <= 1'b0;
    wait_src(5);
    clear_src(5);
    fire_src(20'h2000);
    repeat (6) @(posedge clk);
    fire_src(20'h2000);
    repeat (8) @(posedge clk);
    clear_src(13);
    #1 check(pend[13], 0);
    @(posedge clk) mask <= '0;
  endtask
  task automatic t_powerdown;
    pd <= 1;
    en[8] <= 0;
    fire_src(20'h140);
    repeat (14) @(posedge clk);
    #1 check({nint, pend[8], pend[6]}, 0);
    t_latency(15, 12, 0);
    pd <= 0;
    en[8] <= 1;
  endtask
  task automatic t_contest;
    fire_src(20'hc);
    repeat (11) @(posedge clk);
    #1 check({act, pend[3]}, {5'd2, 1'b1});
    clear_src(2);
    wait_src(3);
    fire_src(20'h8);
    repeat (2) @(posedge clk);
    clr <= 20'h8;
    @(posedge clk) clr <= '0;
    #1 check(pend[3], 0);
    repeat (16) @(posedge clk);
    #1 check({nint, cint, pend[3]}, 0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1;
    repeat (2) @(posedge clk);
    t_sources();
    t_mask_repeat();
    t_powerdown();
    t_contest();
    end_of_test();
  end
  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
endmodule

// ---- verilog/eir_pkg.sv ----
// Package: constants for the external interrupt router
package eir_pkg;
  localparam int unsigned REQ_COUNT      = 4;
  localparam int unsigned STD_COUNT      = 8;
  localparam int unsigned WAKE_COUNT     = 8;
  localparam int unsigned SRC_COUNT      = REQ_COUNT + STD_COUNT + WAKE_COUNT;
  localparam int unsigned SRC_IDX_W      = 5;
  localparam int unsigned REQ_LATENCY    = 10;
  localparam int unsigned PIN_LATENCY    = 12;
  localparam int unsigned SYNC_STAGES    = 2;
  localparam int unsigned STD_BASE       = REQ_COUNT;
  localparam int unsigned WAKE_BASE      = REQ_COUNT + STD_COUNT;
  localparam int unsigned DLY_W          = 4;
  localparam logic [SRC_IDX_W-1:0] NO_SRC = 5'h1f;
  typedef enum logic {EIR_TGT_NORMAL, EIR_TGT_CRITICAL} eir_target_t;
endpackage

// ---- verilog/eir_router.sv ----
// External interrupt router: sync, pending, priority, delivery to core
// Behaviour
// - Four dedicated request pins, eight standard and eight wake-up pins are accepted.
// - An uncontested dedicated request reaches the core 10 cycles after the pin event.
// - An uncontested standard or wake-up pin reaches the normal input after 12 cycles.
// - Every pin passes a two-flop synchroniser before prioritisation.
// - A repeat event while the source is still pending is lost.
// - Standard pin interrupts are disabled in power-down mode.
// - Competing sources are served one at a time, lowest index first.
`timescale 1ns/1ps
module eir_router
  import eir_pkg::*;
(
  input  wire logic                  I_CLOCK,
  input  wire logic                  I_NRST,
  input  wire logic [REQ_COUNT-1:0]  I_EXT_REQUEST,
  input  wire logic [STD_COUNT-1:0]  I_STD_PIN_IRQ,
  input  wire logic [WAKE_COUNT-1:0] I_WAKE_PIN_IRQ,
  input  wire logic [SRC_COUNT-1:0]  I_ENABLE,
  input  wire logic [SRC_COUNT-1:0]  I_MASK,
  input  wire logic [SRC_COUNT-1:0]  I_CLEAR,
  input  wire logic                  I_POWER_DOWN,
  input  wire logic                  I_REQ0_CRITICAL,
  output logic [SRC_COUNT-1:0]       O_PENDING,
  output logic                       O_CORE_INT,
  output logic                       O_CORE_CINT,
  output logic [SRC_IDX_W-1:0]       O_ACTIVE_SRC
);
  // Delay from pin to delivery, after sync (2) and output register (1) and
  // pending register (1); the remainder is a per-class pipeline.
  localparam int unsigned FRONT      = SYNC_STAGES + 2;
  localparam int unsigned REQ_EXTRA  = REQ_LATENCY - FRONT;
  localparam int unsigned PIN_EXTRA  = PIN_LATENCY - FRONT;

  // ----------------------------------------------------------------
  // Synchronisation
  // ----------------------------------------------------------------
  eir_sync_if #(.N(SRC_COUNT)) sync_bus ();

  eir_sync #(.N(SRC_COUNT)) u_sync (
    .i_clk  (I_CLOCK),
    .i_nrst (I_NRST),
    .i_pins ({I_WAKE_PIN_IRQ, I_STD_PIN_IRQ, I_EXT_REQUEST}),
    .sync   (sync_bus.src)
  );

  logic [SRC_COUNT-1:0] level_prev;
  logic [SRC_COUNT-1:0] pin_event;
  logic [SRC_COUNT-1:0] src_allowed;
  logic [SRC_COUNT-1:0] pending;

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      level_prev <= '0;
    end else begin
      level_prev <= sync_bus.level;
    end
  end

  // ----------------------------------------------------------------
  // Event capture and pending flags
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < SRC_COUNT; g++) begin : g_src
      if (g >= STD_BASE && g < WAKE_BASE) begin : g_std
        assign src_allowed[g] = I_ENABLE[g] & ~I_POWER_DOWN;
      end else begin : g_other
        assign src_allowed[g] = I_ENABLE[g];
      end
      assign pin_event[g] = sync_bus.level[g] & ~level_prev[g] & src_allowed[g];

      always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
          pending[g] <= 1'b0;
        end else if (pin_event[g] && !pending[g]) begin
          pending[g] <= 1'b1;
        end else if (I_CLEAR[g]) begin
          pending[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign O_PENDING = pending;

  // ----------------------------------------------------------------
  // Priority select, one source at a time
  // ----------------------------------------------------------------
  logic [SRC_COUNT-1:0] candidate;
  logic [SRC_IDX_W-1:0] next_sel;
  logic                 next_any;

  assign candidate = pending & ~I_MASK;

  always_comb begin
    next_sel = NO_SRC;
    next_any = 1'b0;
    for (int i = SRC_COUNT - 1; i >= 0; i--) begin
      if (candidate[i]) begin
        next_sel = SRC_IDX_W'(i);
        next_any = 1'b1;
      end
    end
  end

  // Shift pipelines per class; the head of each stage holds a selected
  // source index so the fixed latency holds for an uncontested source.
  logic [REQ_EXTRA-1:0] req_pipe;
  logic [PIN_EXTRA-1:0] pin_pipe;
  logic [SRC_IDX_W-1:0] req_idx [REQ_EXTRA];
  logic [SRC_IDX_W-1:0] pin_idx [PIN_EXTRA];
  logic                 is_req;

  assign is_req = next_any && (next_sel < SRC_IDX_W'(REQ_COUNT));

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      req_pipe <= '0;
      pin_pipe <= '0;
      for (int k = 0; k < REQ_EXTRA; k++) req_idx[k] <= NO_SRC;
      for (int k = 0; k < PIN_EXTRA; k++) pin_idx[k] <= NO_SRC;
    end else begin
      req_pipe <= {req_pipe[REQ_EXTRA-2:0], next_any & is_req};
      pin_pipe <= {pin_pipe[PIN_EXTRA-2:0], next_any & ~is_req};
      req_idx[0] <= next_sel;
      pin_idx[0] <= next_sel;
      for (int k = 1; k < REQ_EXTRA; k++) req_idx[k] <= req_idx[k-1];
      for (int k = 1; k < PIN_EXTRA; k++) pin_idx[k] <= pin_idx[k-1];
    end
  end

  // ----------------------------------------------------------------
  // Mapping onto core inputs
  // ----------------------------------------------------------------
  logic                 req_out;
  logic                 pin_out;
  logic [SRC_IDX_W-1:0] out_idx;
  logic                 to_critical;

  assign req_out     = req_pipe[REQ_EXTRA-1] && pending[req_idx[REQ_EXTRA-1]];
  assign pin_out     = pin_pipe[PIN_EXTRA-1] && pending[pin_idx[PIN_EXTRA-1]];
  assign out_idx     = req_out ? req_idx[REQ_EXTRA-1] : pin_idx[PIN_EXTRA-1];
  assign to_critical = req_out && (out_idx == '0) && I_REQ0_CRITICAL;

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_CORE_INT   <= 1'b0;
      O_CORE_CINT  <= 1'b0;
      O_ACTIVE_SRC <= NO_SRC;
    end else begin
      O_CORE_CINT  <= to_critical;
      O_CORE_INT   <= (req_out || pin_out) && !to_critical;
      O_ACTIVE_SRC <= (req_out || pin_out) ? out_idx : NO_SRC;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_req0_event;
    pin_event[0] && !pending[0] && !I_MASK[0] && candidate == '0;
  endsequence

  property p_req_latency;
    @(posedge I_CLOCK) disable iff (!I_NRST)
      (s_req0_event ##1 (candidate == 1)[*7]) |-> ##1 (O_CORE_INT || O_CORE_CINT);
  endproperty
  a_req_latency: assert property (p_req_latency)
    else $error("dedicated request latency wrong");

  sequence s_wake_event;
    pin_event[WAKE_BASE] && !pending[WAKE_BASE] && !I_MASK[WAKE_BASE] && candidate == '0;
  endsequence

  property p_pin_latency;
    @(posedge I_CLOCK) disable iff (!I_NRST)
      (s_wake_event ##1 (candidate == (1 << WAKE_BASE))[*8]
       ##1 (candidate == (1 << WAKE_BASE)))
      |-> ##1 (O_CORE_INT && O_ACTIVE_SRC == SRC_IDX_W'(WAKE_BASE));
  endproperty
  a_pin_latency: assert property (p_pin_latency)
    else $error("pin interrupt latency wrong");

  property p_pd_blocks_std;
    @(posedge I_CLOCK) disable iff (!I_NRST)
      I_POWER_DOWN |=> ((pending[WAKE_BASE-1:STD_BASE]
                         & ~$past(pending[WAKE_BASE-1:STD_BASE])) == '0);
  endproperty
  a_pd_blocks_std: assert property (p_pd_blocks_std)
    else $error("standard pin event in power-down");

  property p_pending_holds;
    @(posedge I_CLOCK) disable iff (!I_NRST)
      (pending[1] && !I_CLEAR[1]) |=> pending[1];
  endproperty
  a_pending_holds: assert property (p_pending_holds)
    else $error("pending dropped without clear");

  property p_set_on_event;
    @(posedge I_CLOCK) disable iff (!I_NRST)
      (pin_event[2] && !pending[2]) |=> pending[2];
  endproperty
  a_set_on_event: assert property (p_set_on_event)
    else $error("event not recorded");

  property p_repeat_lost;
    @(posedge I_CLOCK) disable iff (!I_NRST)
      (pending[3] && I_CLEAR[3] && pin_event[3]) |=> !pending[3];
  endproperty
  a_repeat_lost: assert property (p_repeat_lost)
    else $error("repeat event recorded while pending");

  property p_one_at_a_time;
    @(posedge I_CLOCK) disable iff (!I_NRST)
      $onehot0({O_CORE_INT, O_CORE_CINT})
      && ((O_CORE_INT || O_CORE_CINT) == (O_ACTIVE_SRC != NO_SRC));
  endproperty
  a_one_at_a_time: assert property (p_one_at_a_time)
    else $error("two core inputs driven together");

  property p_sync_delay;
    @(posedge I_CLOCK) disable iff (!I_NRST)
      $rose(sync_bus.level[0]) |-> $past(I_EXT_REQUEST[0], 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("pin not passed through two flops");

  property p_critical_only_req0;
    @(posedge I_CLOCK) disable iff (!I_NRST)
      O_CORE_CINT |-> (O_ACTIVE_SRC == '0 && $past(I_REQ0_CRITICAL));
  endproperty
  a_critical_only_req0: assert property (p_critical_only_req0)
    else $error("critical input from wrong source");
endmodule

// ---- verilog/eir_sync.sv ----
// Two-flop synchronisers for every external interrupt pin
`timescale 1ns/1ps
module eir_sync
  import eir_pkg::*;
#(
  parameter int unsigned N = SRC_COUNT
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic [N-1:0] i_pins,
  eir_sync_if.src           sync
);
  logic [N-1:0] stage1;
  logic [N-1:0] stage2;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= i_pins;
      stage2 <= stage1;
    end
  end

  assign sync.level = stage2;
endmodule

// ---- verilog/eir_sync_if.sv ----
// Interface: synchronised pin levels handed to the router core
`timescale 1ns/1ps
interface eir_sync_if #(parameter int unsigned N = 20);
  logic [N-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface
